// File: rtl/msg_group_if.sv
`timescale 1ns/1ps
interface msg_group_if;
  logic [15:0] cond;
  logic [15:0] wdata;
  logic wr_enable;
  logic wr_ptr;
  logic wr_ntr;
  logic rd_event;
  logic clear_all;
  logic [15:0] event_val;
  logic [15:0] enable_val;
  logic [15:0] ptr_val;
  logic [15:0] ntr_val;
  logic summary;
  modport ctrl (
    output cond, wdata, wr_enable, wr_ptr, wr_ntr, rd_event, clear_all,
    input event_val, enable_val, ptr_val, ntr_val, summary
  );
  modport grp (
    input cond, wdata, wr_enable, wr_ptr, wr_ntr, rd_event, clear_all,
    output event_val, enable_val, ptr_val, ntr_val, summary
  );
endinterface

// File: rtl/msg_pkg.sv
// Functional notes
// - Host writes a quality enable mask; enabled quality events form one summary bit.
// - Quality bit 3 sets on corrupt data, input overload or math-channel log fault.
// - Quality bit 3 clears when a measurement completes with none of those errors.
// - Quality bit 8 sets when zeroing or calibration reports a zero or cal error.
// - Quality bit 8 clears when zeroing or calibration succeeds without error.
// - Quality bit 9 follows the power-on self-test: set on fail, clear on pass.
// - Progress bit 0 sets when zeroing or calibration begins, including calibrate-all.
// - Progress bit 0 clears once the running zeroing or calibration finishes.
// - Progress bit 4 is high while a measurement runs, low once it completes.
// - Progress bit 5 sets entering wait-for-trigger and clears on returning to idle.
// - Progress bit 10 is set only while sensor data is read from EEPROM.
// - Progress bit 11 sets when a completed measurement fails the lower limit.
// - Progress bit 11 clears after a measurement with lower test off or passing.
// - Progress bit 12 sets when a completed measurement fails the upper limit.
// - Progress bit 12 clears after a measurement with upper test off or passing.
// - Both groups are 16 bits; bit 15 and unassigned bits always read zero.
// - Summary is OR of event AND enable; reading enable leaves it unchanged.
// - Event bits stay set until the event register is read or status is cleared.
package msg_pkg;
  localparam int GRP_W = 16;
  localparam int NUM_GRP = 2;
  localparam logic GRP_QUALITY = 1'h0;
  localparam logic GRP_PROGRESS = 1'h1;
  localparam int Q_POWER_BIT = 3;
  localparam int Q_CAL_BIT = 8;
  localparam int Q_SELFTEST_BIT = 9;
  localparam int P_CAL_BIT = 0;
  localparam int P_MEAS_BIT = 4;
  localparam int P_TRIG_BIT = 5;
  localparam int P_EEPROM_BIT = 10;
  localparam int P_LOWER_BIT = 11;
  localparam int P_UPPER_BIT = 12;
  localparam logic [15:0] Q_USED_MASK = 16'h0308;
  localparam logic [15:0] P_USED_MASK = 16'h1C31;
  localparam logic [15:0] COND_RESET = 16'h0000;
  localparam logic [15:0] EVENT_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] PTR_RESET = 16'hFFFF;
  localparam logic [15:0] NTR_RESET = 16'h0000;
  typedef enum logic [2:0] {
    CMD_RD_COND = 3'h0,
    CMD_RD_EVENT = 3'h1,
    CMD_RD_ENABLE = 3'h2,
    CMD_WR_ENABLE = 3'h3,
    CMD_RD_PTR = 3'h4,
    CMD_WR_PTR = 3'h5,
    CMD_WR_NTR = 3'h6,
    CMD_CLEAR_STATUS = 3'h7
  } msg_cmd_t;
endpackage

// File: rtl/msg_status_group.sv
`timescale 1ns/1ps
module msg_status_group #(
  parameter logic [15:0] USED_MASK = 16'h0000
) (
  input wire logic clk,
  input wire logic reset,
  msg_group_if.grp g
);
  import msg_pkg::*;

  logic [15:0] cond_prev_q;
  logic [15:0] event_q;
  logic [15:0] event_d;
  logic [15:0] enable_q;
  logic [15:0] enable_d;
  logic [15:0] ptr_q;
  logic [15:0] ntr_q;
  logic summary_q;
  logic [15:0] rise;
  logic [15:0] fall;

  assign rise = g.cond & ~cond_prev_q;
  assign fall = ~g.cond & cond_prev_q;

  // A new transition in the clearing cycle survives the clear.
  always_comb begin
    event_d = event_q;
    if (g.rd_event || g.clear_all) begin
      event_d = EVENT_RESET;
    end
    event_d = (event_d | (rise & ptr_q) | (fall & ntr_q)) & USED_MASK;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cond_prev_q <= COND_RESET;
    end else begin
      cond_prev_q <= g.cond;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      event_q <= EVENT_RESET;
    end else begin
      event_q <= event_d;
    end
  end

  // The summary sees a new mask on the same edge that stores it, so it never lags a write.
  always_comb begin
    enable_d = enable_q;
    if (g.wr_enable) begin
      enable_d = g.wdata & USED_MASK;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_q <= ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_q <= PTR_RESET & USED_MASK;
      ntr_q <= NTR_RESET & USED_MASK;
    end else begin
      if (g.wr_ptr) begin
        ptr_q <= g.wdata & USED_MASK;
      end
      if (g.wr_ntr) begin
        ntr_q <= g.wdata & USED_MASK;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= |(event_d & enable_d);
    end
  end

  assign g.event_val = event_q;
  assign g.enable_val = enable_q;
  assign g.ptr_val = ptr_q;
  assign g.ntr_val = ntr_q;
  assign g.summary = summary_q;
endmodule

// File: rtl/msg_status_top.sv
`timescale 1ns/1ps
module msg_status_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire msg_pkg::msg_cmd_t cmd_op,
  input wire logic cmd_group,
  input wire logic [15:0] cmd_wdata,
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic meas_err_corrupt,
  input wire logic meas_err_overload,
  input wire logic [3:0] math_channel_log_err,
  input wire logic lower_test_enabled,
  input wire logic lower_test_fail,
  input wire logic upper_test_enabled,
  input wire logic upper_test_fail,
  input wire logic cal_start,
  input wire logic cal_done,
  input wire logic cal_zero_err,
  input wire logic cal_cal_err,
  input wire logic selftest_done,
  input wire logic selftest_pass,
  input wire logic trig_wait_enter,
  input wire logic trig_idle_enter,
  input wire logic eeprom_reading,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic quality_summary,
  output logic progress_summary
);
  import msg_pkg::*;

  logic [15:0] qual_cond_q;
  logic [15:0] prog_cond_q;
  logic rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic [15:0] cond_arr [NUM_GRP];
  logic [15:0] event_arr [NUM_GRP];
  logic [15:0] enable_arr [NUM_GRP];
  logic [15:0] ptr_arr [NUM_GRP];
  logic [NUM_GRP-1:0] summary_arr;
  logic meas_err_any;

  msg_group_if grp_if [NUM_GRP] ();

  assign meas_err_any = meas_err_corrupt | meas_err_overload | (|math_channel_log_err);

  //////////////////////////////////////////////////////////////////////////////
  // Measurement-quality condition bits.

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      qual_cond_q[Q_POWER_BIT] <= 1'b0;
    end else if (meas_done) begin
      qual_cond_q[Q_POWER_BIT] <= meas_err_any;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      qual_cond_q[Q_CAL_BIT] <= 1'b0;
    end else if (cal_done) begin
      qual_cond_q[Q_CAL_BIT] <= cal_zero_err | cal_cal_err;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      qual_cond_q[Q_SELFTEST_BIT] <= 1'b0;
    end else if (selftest_done) begin
      qual_cond_q[Q_SELFTEST_BIT] <= ~selftest_pass;
    end
  end

  // Unassigned positions are held at zero.
  genvar b;
  generate
    for (b = 0; b < GRP_W; b++) begin : g_qual_unused
      if (!Q_USED_MASK[b]) begin : g_zero
        assign qual_cond_q[b] = 1'b0;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Measurement-progress condition bits.

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_cond_q[P_CAL_BIT] <= 1'b0;
    end else if (cal_start) begin
      prog_cond_q[P_CAL_BIT] <= 1'b1;
    end else if (cal_done) begin
      prog_cond_q[P_CAL_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_cond_q[P_MEAS_BIT] <= 1'b0;
    end else if (meas_start) begin
      prog_cond_q[P_MEAS_BIT] <= 1'b1;
    end else if (meas_done) begin
      prog_cond_q[P_MEAS_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_cond_q[P_TRIG_BIT] <= 1'b0;
    end else if (trig_idle_enter) begin
      prog_cond_q[P_TRIG_BIT] <= 1'b0;
    end else if (trig_wait_enter) begin
      prog_cond_q[P_TRIG_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_cond_q[P_EEPROM_BIT] <= 1'b0;
    end else begin
      prog_cond_q[P_EEPROM_BIT] <= eeprom_reading;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_cond_q[P_LOWER_BIT] <= 1'b0;
      prog_cond_q[P_UPPER_BIT] <= 1'b0;
    end else if (meas_done) begin
      prog_cond_q[P_LOWER_BIT] <= lower_test_enabled & lower_test_fail;
      prog_cond_q[P_UPPER_BIT] <= upper_test_enabled & upper_test_fail;
    end
  end

  generate
    for (b = 0; b < GRP_W; b++) begin : g_prog_unused
      if (!P_USED_MASK[b]) begin : g_zero
        assign prog_cond_q[b] = 1'b0;
      end
    end
  endgenerate

  assign cond_arr[GRP_QUALITY] = qual_cond_q;
  assign cond_arr[GRP_PROGRESS] = prog_cond_q;

  //////////////////////////////////////////////////////////////////////////////
  // Status groups.

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GRP; gi++) begin : g_grp
      logic sel;
      assign sel = cmd_valid && (cmd_group == 1'(gi));
      assign grp_if[gi].cond = cond_arr[gi];
      assign grp_if[gi].wdata = cmd_wdata;
      assign grp_if[gi].wr_enable = sel && (cmd_op == CMD_WR_ENABLE);
      assign grp_if[gi].wr_ptr = sel && (cmd_op == CMD_WR_PTR);
      assign grp_if[gi].wr_ntr = sel && (cmd_op == CMD_WR_NTR);
      assign grp_if[gi].rd_event = sel && (cmd_op == CMD_RD_EVENT);
      assign grp_if[gi].clear_all = cmd_valid && (cmd_op == CMD_CLEAR_STATUS);
      assign event_arr[gi] = grp_if[gi].event_val;
      assign enable_arr[gi] = grp_if[gi].enable_val;
      assign ptr_arr[gi] = grp_if[gi].ptr_val;
      assign summary_arr[gi] = grp_if[gi].summary;
      msg_status_group #(
        .USED_MASK(gi == 0 ? Q_USED_MASK : P_USED_MASK)
      ) u_group (
        .clk(clk),
        .reset(reset),
        .g(grp_if[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Query answers, one cycle after the command.

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= cmd_valid && (cmd_op == CMD_RD_COND || cmd_op == CMD_RD_EVENT ||
                                   cmd_op == CMD_RD_ENABLE || cmd_op == CMD_RD_PTR);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_data_q <= 16'h0000;
    end else if (cmd_valid) begin
      case (cmd_op)
        CMD_RD_COND: begin
          rsp_data_q <= cond_arr[cmd_group];
        end
        CMD_RD_EVENT: begin
          rsp_data_q <= event_arr[cmd_group];
        end
        CMD_RD_ENABLE: begin
          rsp_data_q <= enable_arr[cmd_group];
        end
        CMD_RD_PTR: begin
          rsp_data_q <= ptr_arr[cmd_group];
        end
        default: begin
          rsp_data_q <= rsp_data_q;
        end
      endcase
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign quality_summary = summary_arr[GRP_QUALITY];
  assign progress_summary = summary_arr[GRP_PROGRESS];
endmodule

// File: test/msg_host_model.sv
`timescale 1ns/1ps
module msg_host_model import msg_pkg::*; (
  input wire logic clk,
  output logic cmd_valid,
  output msg_pkg::msg_cmd_t cmd_op,
  output logic cmd_group,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = CMD_RD_COND;
    cmd_group = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // One command, or the same command on two back-to-back cycles.
  task automatic cmd(input msg_cmd_t op, input logic grp, input logic [15:0] wd,
    input int reps, output logic ok, output logic [15:0] d0, output logic [15:0] d1);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_group <= grp;
    cmd_wdata <= wd;
    @(posedge clk);
    ok = 1'b1;
    d0 = 16'h0000;
    if (reps > 1) begin
      @(posedge clk);
      ok = rsp_valid;
      d0 = rsp_data;
    end
    cmd_valid <= 1'b0;
    cmd_wdata <= ~wd;
    @(posedge clk);
    ok = ok & rsp_valid;
    d1 = rsp_data;
  endtask
endmodule

// File: test/msg_status_chk.sv
`timescale 1ns/1ps
module msg_status_chk import msg_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire msg_pkg::msg_cmd_t cmd_op,
  input wire logic cmd_group,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic quality_summary,
  input wire logic progress_summary
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic rd_cmd;
  logic q_clr;
  logic p_clr;
  assign rd_cmd = cmd_valid && (cmd_op inside {CMD_RD_COND, CMD_RD_EVENT, CMD_RD_ENABLE, CMD_RD_PTR});
  // Only these commands may take an event or its enable away.
  assign q_clr = cmd_valid && (cmd_op == CMD_CLEAR_STATUS
    || !cmd_group && (cmd_op == CMD_RD_EVENT || cmd_op == CMD_WR_ENABLE));
  assign p_clr = cmd_valid && (cmd_op == CMD_CLEAR_STATUS
    || cmd_group && (cmd_op == CMD_RD_EVENT || cmd_op == CMD_WR_ENABLE));
  chk_rsp_timing: assert property (rd_cmd |=> rsp_valid)
    else $error("read got no answer");
  chk_rsp_cause: assert property (rsp_valid |-> $past(rd_cmd))
    else $error("answer without read");
  chk_bit15_zero: assert property (rsp_valid |-> !rsp_data[15])
    else $error("bit 15 set");
  chk_qual_unused: assert property (rsp_valid && $past(cmd_op) != CMD_RD_PTR
    && !$past(cmd_group) |-> (rsp_data & ~Q_USED_MASK) == 16'h0000)
    else $error("unused quality bit set");
  chk_prog_unused: assert property (rsp_valid && $past(cmd_op) != CMD_RD_PTR
    && $past(cmd_group) |-> (rsp_data & ~P_USED_MASK) == 16'h0000)
    else $error("unused progress bit set");
  chk_qsum_sticky: assert property ($fell(quality_summary) |-> $past(q_clr))
    else $error("quality summary dropped alone");
  chk_psum_sticky: assert property ($fell(progress_summary) |-> $past(p_clr))
    else $error("progress summary dropped alone");
  chk_enable_reread: assert property ((cmd_valid && cmd_op == CMD_RD_ENABLE) ##1
    (cmd_valid && cmd_op == CMD_RD_ENABLE && $stable(cmd_group)) |=> $stable(rsp_data))
    else $error("enable changed by read");
  cover property (q_clr && quality_summary);
  cover property (rd_cmd && cmd_op == CMD_RD_EVENT);
  cover property ($rose(progress_summary));
endmodule
bind msg_status_top msg_status_chk i_msg_status_chk (.clk(clk), .reset(reset),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_group(cmd_group), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .quality_summary(quality_summary), .progress_summary(progress_summary));

// File: test/msg_status_top_test.sv
`timescale 1ns/1ps
module msg_status_top_test;
  import msg_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic eeprom_reading = 1'b0;
  logic [19:0] evt = 20'h00000;
  logic meas_start, meas_done, meas_err_corrupt, meas_err_overload;
  logic lower_test_enabled, lower_test_fail, upper_test_enabled, upper_test_fail;
  logic cal_start, cal_done, cal_zero_err, cal_cal_err, selftest_done, selftest_pass;
  logic trig_wait_enter, trig_idle_enter, cmd_valid, cmd_group, rsp_valid;
  logic quality_summary, progress_summary;
  logic [3:0] math_channel_log_err;
  logic [15:0] cmd_wdata, rsp_data;
  msg_cmd_t cmd_op;
  int error_cnt = 0;
  int n_checks = 0;
  assign {meas_start, meas_done, meas_err_corrupt, meas_err_overload, math_channel_log_err,
    lower_test_enabled, lower_test_fail, upper_test_enabled, upper_test_fail, cal_start,
    cal_done, cal_zero_err, cal_cal_err, selftest_done, selftest_pass, trig_wait_enter,
    trig_idle_enter} = evt;
  always #12.5 clk = ~clk;
  msg_status_top i_msg_status_top (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_group(cmd_group), .cmd_wdata(cmd_wdata), .meas_start(meas_start),
    .meas_done(meas_done), .meas_err_corrupt(meas_err_corrupt),
    .meas_err_overload(meas_err_overload), .math_channel_log_err(math_channel_log_err),
    .lower_test_enabled(lower_test_enabled), .lower_test_fail(lower_test_fail),
    .upper_test_enabled(upper_test_enabled), .upper_test_fail(upper_test_fail),
    .cal_start(cal_start), .cal_done(cal_done), .cal_zero_err(cal_zero_err),
    .cal_cal_err(cal_cal_err), .selftest_done(selftest_done), .selftest_pass(selftest_pass),
    .trig_wait_enter(trig_wait_enter), .trig_idle_enter(trig_idle_enter),
    .eeprom_reading(eeprom_reading), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .quality_summary(quality_summary), .progress_summary(progress_summary));
  msg_host_model i_msg_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_group(cmd_group), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdm(input msg_cmd_t op, input logic grp, input logic [15:0] m,
    input logic [15:0] e);
    logic ok;
    logic [15:0] d0;
    logic [15:0] d;
    i_msg_host_model.cmd(op, grp, 16'h0000, 1, ok, d0, d);
    chk({15'h0000, ok}, 16'h0001);
    chk(d & m, e);
  endtask
  task automatic wr(input msg_cmd_t op, input logic grp, input logic [15:0] wd);
    logic ok;
    logic [15:0] d0;
    logic [15:0] d1;
    i_msg_host_model.cmd(op, grp, wd, 1, ok, d0, d1);
  endtask
  // Bit order of the pulse word follows the concatenation onto evt.
  task automatic ev(input logic [19:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 20'h00000;
  endtask
  task automatic s_reset;
    rdm(CMD_RD_COND, GRP_QUALITY, 16'hFFFF, COND_RESET);
    rdm(CMD_RD_EVENT, GRP_PROGRESS, 16'hFFFF, EVENT_RESET);
    rdm(CMD_RD_ENABLE, GRP_QUALITY, 16'hFFFF, ENABLE_RESET);
  endtask
  task automatic s_enable;
    logic ok;
    logic [15:0] a;
    logic [15:0] b;
    wr(CMD_WR_ENABLE, GRP_QUALITY, 16'hFFFF);
    wr(CMD_WR_ENABLE, GRP_PROGRESS, 16'hFFFF);
    i_msg_host_model.cmd(CMD_RD_ENABLE, GRP_QUALITY, 16'h0000, 2, ok, a, b);
    chk(a, Q_USED_MASK);
    chk(b, Q_USED_MASK);
  endtask
  task automatic s_power;
    for (int i = 0; i < 6; i++) begin
      ev(20'h80000);
      rdm(CMD_RD_COND, GRP_PROGRESS, 16'h0010, 16'h0010);
      chk({15'h0000, progress_summary}, 16'h0001);
      ev(20'h40000 | (i < 2 ? 20'h20000 >> i : 20'h01000 << (i - 2)));
      rdm(CMD_RD_COND, GRP_QUALITY, 16'hFFFF, 16'h0008);
      rdm(CMD_RD_COND, GRP_PROGRESS, 16'h0010, 16'h0000);
      chk({15'h0000, quality_summary}, 16'h0001);
      ev(20'h40000);
      rdm(CMD_RD_COND, GRP_QUALITY, 16'hFFFF, 16'h0000);
      rdm(CMD_RD_EVENT, GRP_QUALITY, 16'hFFFF, 16'h0008);
      chk({15'h0000, quality_summary}, 16'h0000);
      rdm(CMD_RD_EVENT, GRP_QUALITY, 16'hFFFF, 16'h0000);
    end
  endtask
  task automatic s_cal;
    for (int e = 0; e < 2; e++) begin
      ev(20'h00080);
      rdm(CMD_RD_COND, GRP_PROGRESS, 16'h0001, 16'h0001);
      ev(20'h00040 | (20'h00020 >> e));
      rdm(CMD_RD_COND, GRP_QUALITY, 16'h0100, 16'h0100);
      rdm(CMD_RD_COND, GRP_PROGRESS, 16'h0001, 16'h0000);
      ev(20'h00080);
      ev(20'h00040);
      rdm(CMD_RD_COND, GRP_QUALITY, 16'h0100, 16'h0000);
    end
  endtask
  task automatic s_limits;
    ev(20'h40F00);
    rdm(CMD_RD_COND, GRP_PROGRESS, 16'h1800, 16'h1800);
    wr(CMD_CLEAR_STATUS, GRP_QUALITY, 16'h0000);
    chk({15'h0000, progress_summary}, 16'h0000);
    ev(20'h40C00);
    rdm(CMD_RD_COND, GRP_PROGRESS, 16'h1800, 16'h0800);
    ev(20'h40300);
    rdm(CMD_RD_COND, GRP_PROGRESS, 16'h1800, 16'h1000);
    ev(20'h40A00);
    rdm(CMD_RD_COND, GRP_PROGRESS, 16'h1800, 16'h0000);
  endtask
  task automatic s_misc;
    ev(20'h00008);
    rdm(CMD_RD_COND, GRP_QUALITY, 16'h0200, 16'h0200);
    ev(20'h0000C);
    rdm(CMD_RD_COND, GRP_QUALITY, 16'h0200, 16'h0000);
    ev(20'h00002);
    rdm(CMD_RD_COND, GRP_PROGRESS, 16'h0020, 16'h0020);
    ev(20'h00003);
    rdm(CMD_RD_COND, GRP_PROGRESS, 16'h0020, 16'h0000);
    @(posedge clk);
    eeprom_reading <= 1'b1;
    rdm(CMD_RD_COND, GRP_PROGRESS, 16'h0400, 16'h0400);
    eeprom_reading <= 1'b0;
    rdm(CMD_RD_COND, GRP_PROGRESS, 16'h0400, 16'h0000);
  endtask
  // Falling edges only on the quality group, then a partial enable mask.
  task automatic s_filter;
    rdm(CMD_RD_PTR, GRP_PROGRESS, 16'hFFFF, P_USED_MASK);
    wr(CMD_WR_PTR, GRP_QUALITY, 16'h0000);
    wr(CMD_WR_NTR, GRP_QUALITY, 16'hFFFF);
    ev(20'h60000);
    rdm(CMD_RD_EVENT, GRP_QUALITY, 16'hFFFF, 16'h0200);
    ev(20'h40000);
    wr(CMD_WR_ENABLE, GRP_QUALITY, 16'h0200);
    chk({15'h0000, quality_summary}, 16'h0000);
    wr(CMD_WR_ENABLE, GRP_QUALITY, 16'hFFFF);
    chk({15'h0000, quality_summary}, 16'h0001);
    rdm(CMD_RD_EVENT, GRP_QUALITY, 16'hFFFF, 16'h0008);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    s_reset;
    s_enable;
    s_power;
    s_cal;
    s_limits;
    s_misc;
    s_filter;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("BAD %0t run did not finish", $time);
    final_report;
  end
endmodule
